// ---- hdl/bcs_sequencer.sv ----
// Boot clock and reset sequencer with per-module clock enables.
`timescale 1ns/1ps

module bcs_sequencer
    import bcs_pkg::*;
#(
    parameter int NUM_MODULES = BCS_NUM_MODULES,
    parameter int DIV_W = BCS_DIV_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic por_stable,
    input wire logic cfg_load,
    input wire logic [BCS_NUM_PLLS-1:0] cfg_pll_en,
    input wire bcs_src_e cfg_clk_src,
    input wire logic [NUM_MODULES*DIV_W-1:0] cfg_div,
    input wire logic [NUM_MODULES-1:0] cfg_gate,
    output logic sys_rst,
    output bcs_src_e clk_src,
    output logic [BCS_NUM_PLLS-1:0] pll_en,
    output logic [NUM_MODULES-1:0] mod_clk_en,
    output logic fetch_req,
    output logic [31:0] fetch_addr
);

    // Refuse structures the divider logic cannot serve.
    if (NUM_MODULES < 1 || DIV_W < 1) begin : g_bad_param
        $error("bcs_sequencer: NUM_MODULES and DIV_W must be at least 1");
    end

    // A PLL source is only usable when that PLL is enabled.
    function automatic logic src_usable(input bcs_src_e src,
                                        input logic [BCS_NUM_PLLS-1:0] en);
        logic ok;
        ok = BCS_ACTIVE;
        if (src == BCS_SRC_PLL0) begin
            ok = en[BCS_PLL0_BIT];
        end else if (src == BCS_SRC_PLL1) begin
            ok = en[BCS_PLL1_BIT];
        end
        return ok;
    endfunction : src_usable

    logic por_meta_reg;
    logic por_sync_reg;
    logic sys_rst_reg;
    logic sys_rst_next;
    logic fetch_req_reg;
    logic fetch_req_next;
    logic [31:0] fetch_addr_reg;
    logic [31:0] fetch_addr_next;
    logic cfg_take;
    logic [BCS_NUM_PLLS-1:0] pll_reg;
    logic [BCS_NUM_PLLS-1:0] pll_next;
    bcs_src_e src_reg;
    bcs_src_e src_next;
    logic [NUM_MODULES-1:0] gate_reg;
    logic [NUM_MODULES-1:0] gate_next;
    logic [DIV_W-1:0] div_reg [NUM_MODULES];
    logic [DIV_W-1:0] div_next [NUM_MODULES];
    logic [NUM_MODULES-1:0] en_reg;
    logic [NUM_MODULES-1:0] en_next;

    // Two-flop synchroniser for the power-good level; only the second
    // stage is looked at, so a slow supply edge never splits the release.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            por_meta_reg <= BCS_IDLE;
            por_sync_reg <= BCS_IDLE;
        end else begin
            por_meta_reg <= por_stable;
            por_sync_reg <= por_meta_reg;
        end
    end

    // Reset and boot fetch: reset follows the synchronised power level and
    // drops on one clock edge; the fetch request marks that edge.
    always_comb begin
        sys_rst_next = !por_sync_reg;
        fetch_req_next = sys_rst_reg && por_sync_reg;
        fetch_addr_next = BCS_RESET_VECTOR;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_rst_reg <= BCS_ACTIVE;
            fetch_req_reg <= BCS_IDLE;
            fetch_addr_reg <= BCS_RESET_VECTOR;
        end else begin
            sys_rst_reg <= sys_rst_next;
            fetch_req_reg <= fetch_req_next;
            fetch_addr_reg <= fetch_addr_next;
        end
    end

    // Software configuration is accepted only once the system runs.
    assign cfg_take = cfg_load && !sys_rst_reg;

    // Clock configuration: defaults while in reset, software values after.
    always_comb begin
        pll_next = pll_reg;
        src_next = src_reg;
        gate_next = gate_reg;
        div_next = div_reg;
        if (sys_rst_reg || !por_sync_reg) begin
            pll_next = BCS_PLL_EN_RST;
            src_next = BCS_SRC_RC;
            gate_next = {NUM_MODULES{BCS_GATE_RST}};
            for (int i = 0; i < NUM_MODULES; i++) begin
                div_next[i] = '0;
            end
        end else if (cfg_take) begin
            pll_next = cfg_pll_en;
            src_next = src_usable(cfg_clk_src, cfg_pll_en) ? cfg_clk_src
                                                          : BCS_SRC_RC;
            gate_next = cfg_gate;
            for (int i = 0; i < NUM_MODULES; i++) begin
                div_next[i] = cfg_div[i*DIV_W +: DIV_W];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pll_reg <= BCS_PLL_EN_RST;
            src_reg <= BCS_SRC_RC;
            gate_reg <= {NUM_MODULES{BCS_GATE_RST}};
            for (int i = 0; i < NUM_MODULES; i++) begin
                div_reg[i] <= '0;
            end
        end else begin
            pll_reg <= pll_next;
            src_reg <= src_next;
            gate_reg <= gate_next;
            div_reg <= div_next;
        end
    end

    // Per-module divider: a divide value d gives one enable in d+1 cycles,
    // so zero means undivided; a gated module gets no enable at all.
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
        logic [DIV_W-1:0] cnt_reg;
        logic [DIV_W-1:0] cnt_next;

        always_comb begin
            if (sys_rst_reg) begin
                cnt_next = '0;
                en_next[m] = BCS_ACTIVE;
            end else if (gate_reg[m]) begin
                cnt_next = '0;
                en_next[m] = BCS_IDLE;
            end else if (cnt_reg >= div_reg[m]) begin
                cnt_next = '0;
                en_next[m] = BCS_ACTIVE;
            end else begin
                cnt_next = DIV_W'(cnt_reg + 1'h1);
                en_next[m] = BCS_IDLE;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                cnt_reg <= '0;
                en_reg[m] <= BCS_ACTIVE;
            end else begin
                cnt_reg <= cnt_next;
                en_reg[m] <= en_next[m];
            end
        end
    end

    // Outputs come straight from registers.
    assign sys_rst = sys_rst_reg;
    assign clk_src = src_reg;
    assign pll_en = pll_reg;
    assign mod_clk_en = en_reg;
    assign fetch_req = fetch_req_reg;
    assign fetch_addr = fetch_addr_reg;

    // Checks of the start-up sequence and of the software configuration.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_power_up;
        !por_sync_reg ##1 por_sync_reg;
    endsequence

    sequence s_release;
        $fell(sys_rst_reg);
    endsequence

    property p_rst_hold;
        !por_sync_reg |=> sys_rst_reg [*1];
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("reset not held while power unstable");

    property p_sync_release;
        s_power_up ##1 por_sync_reg |-> !sys_rst_reg && fetch_req_reg;
    endproperty
    a_sync_release: assert property (p_sync_release)
        else $error("reset release not on the synchronised edge");

    property p_src_rc;
        s_release |-> clk_src == BCS_SRC_RC;
    endproperty
    a_src_rc: assert property (p_src_rc)
        else $error("system clock not RC at release");

    property p_pll_off;
        ($past(pll_reg) == BCS_PLL_EN_RST && !$past(cfg_take))
            |-> pll_reg == BCS_PLL_EN_RST;
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("PLL enabled without software request");

    // A load on the release edge itself may legally gate a module two
    // cycles on, so only a release without a load is held to the defaults.
    property p_all_clocks;
        s_release ##0 !cfg_take |=> &en_reg [*2];
    endproperty
    a_all_clocks: assert property (p_all_clocks)
        else $error("module clock not running undivided after start");

    property p_fetch;
        s_release |-> fetch_req_reg && fetch_addr_reg == BCS_RESET_VECTOR;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("first fetch not at reset vector");

    property p_cfg_pll;
        cfg_take && por_sync_reg |=> pll_reg == $past(cfg_pll_en);
    endproperty
    a_cfg_pll: assert property (p_cfg_pll)
        else $error("PLL enable not taken from software");

    property p_cfg_gate;
        (cfg_take && por_sync_reg && cfg_gate[0]) ##1
            (!cfg_take && !sys_rst_reg) |=> !en_reg[0];
    endproperty
    a_cfg_gate: assert property (p_cfg_gate)
        else $error("gated module still clocked");

endmodule : bcs_sequencer

// ---- hdl/bcs_pkg.sv ----
// Shared constants and types of the boot clock and reset sequencer.
package bcs_pkg;

    // First fetch address: the start of internal flash.
    localparam logic [31:0] BCS_RESET_VECTOR = 32'h8000_0000;

    // Default structure figures of the sequencer.
    localparam int BCS_NUM_MODULES = 8;
    localparam int BCS_DIV_W = 4;
    localparam int BCS_NUM_PLLS = 2;

    // Start-up values of the clock configuration.
    localparam logic [BCS_NUM_PLLS-1:0] BCS_PLL_EN_RST = 2'h0;
    localparam logic BCS_GATE_RST = 1'h0;
    localparam logic BCS_ACTIVE = 1'h1;
    localparam logic BCS_IDLE = 1'h0;

    // Bit positions of the two PLL enables.
    localparam int BCS_PLL0_BIT = 0;
    localparam int BCS_PLL1_BIT = 1;

    // System clock sources.
    typedef enum logic [1:0] {
        BCS_SRC_RC,
        BCS_SRC_PLL0,
        BCS_SRC_PLL1
    } bcs_src_e;

endpackage : bcs_pkg

// ---- sim/bcs_core_model.sv ----
// Behavioural model of the processor core that takes the first fetch.
`timescale 1ns/1ps

module bcs_core_model
    import bcs_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output int fetch_cnt,
    output logic [31:0] boot_addr
);
    // The core holds still in reset and latches the address it boots from.
    initial fetch_cnt = 0;
    always @(posedge clock) begin
        if (!sys_rst && fetch_req) begin
            fetch_cnt <= fetch_cnt + 1;
            boot_addr <= fetch_addr;
        end
    end
endmodule : bcs_core_model

// ---- sim/boot_clock_reset_sequencer_tb_top.sv ----
// Self-checking testbench of the boot clock and reset sequencer.
`timescale 1ns/1ps

module boot_clock_reset_sequencer_tb_top;
    import bcs_pkg::*;
    logic clock, rst, por_stable, cfg_load, sys_rst, fetch_req;
    logic [1:0] cfg_pll_en, pll_en;
    bcs_src_e cfg_clk_src, clk_src;
    logic [31:0] cfg_div, fetch_addr, boot_addr;
    logic [7:0] cfg_gate, mod_clk_en;
    int fail_count, n_checks, fetch_cnt, i, hi1, hi2, f0;

    bcs_sequencer dut_u (.clock(clock), .rst(rst), .por_stable(por_stable),
        .cfg_load(cfg_load), .cfg_pll_en(cfg_pll_en),
        .cfg_clk_src(cfg_clk_src), .cfg_div(cfg_div), .cfg_gate(cfg_gate),
        .sys_rst(sys_rst), .clk_src(clk_src), .pll_en(pll_en),
        .mod_clk_en(mod_clk_en), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr));
    bcs_core_model core_u (.clock(clock), .sys_rst(sys_rst),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_cnt(fetch_cnt), .boot_addr(boot_addr));

    // Clock of 4 ns period.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Counts a comparison and reports a mismatch.
    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            $display("BAD %0t %s", $time, m);
            fail_count++;
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Drives one configuration strobe for a single cycle, then lets a cycle
    // pass so that back-to-back loads never reassign the strobe at once.
    task load(input logic [1:0] p, input bcs_src_e s, input logic [7:0] g);
        cfg_pll_en = p;
        cfg_clk_src = s;
        cfg_gate = g;
        cfg_load = 1'b1;
        @(negedge clock);
        cfg_load = 1'b0;
        @(negedge clock);
    endtask : load

    // Checks the start-up defaults of every output except fetch_addr.
    task check_defaults();
        chk(sys_rst === 1'b1, "reset not held");
        chk(clk_src === BCS_SRC_RC, "source not RC");
        chk(pll_en === 2'h0, "PLL enabled at start");
        chk(mod_clk_en === 8'hFF, "module clock not running");
        chk(fetch_req === 1'b0, "fetch during reset");
    endtask : check_defaults

    // Power comes good: release after three edges with one fetch pulse.
    task power_up();
        f0 = fetch_cnt;
        por_stable = 1'b1;
        i = 0;
        while (sys_rst !== 1'b0 && i < 10) begin
            @(negedge clock);
            i++;
        end
        chk(i == 3, "release latency");
        chk(fetch_req === 1'b1, "no fetch at release");
        chk(fetch_addr === BCS_RESET_VECTOR, "fetch address");
        if (i >= 10) stop_test();
        @(negedge clock);
        chk(fetch_req === 1'b0, "fetch pulse too long");
        chk(fetch_cnt == f0 + 1 && boot_addr === 32'h8000_0000, "boot");
    endtask : power_up

    // Software takes over: PLLs, source fallback, dividers and gating.
    task reconfigure();
        load(2'h1, BCS_SRC_PLL0, 8'h01);
        chk(pll_en === 2'h1 && clk_src === BCS_SRC_PLL0, "PLL0");
        @(negedge clock);
        chk(mod_clk_en[0] === 1'b0, "gate ignored");
        load(2'h1, BCS_SRC_PLL1, 8'h00);
        chk(clk_src === BCS_SRC_RC, "no fallback to RC");
        load(2'h3, BCS_SRC_PLL1, 8'h00);
        chk(pll_en === 2'h3 && clk_src === BCS_SRC_PLL1, "PLL1");
        cfg_div[7:4] = 4'h2;
        load(2'h0, BCS_SRC_RC, 8'h00);
        chk(clk_src === BCS_SRC_RC && pll_en === 2'h0, "back to RC");
        @(negedge clock);
        hi1 = 0;
        hi2 = 0;
        repeat (9) begin
            @(negedge clock);
            hi1 += (mod_clk_en[1] === 1'b1);
            hi2 += (mod_clk_en[2] === 1'b1);
        end
        chk(hi1 == 3, "divide by three");
        chk(hi2 == 9, "undivided module");
    endtask : reconfigure

    // Supply drops under a non-default setup: reset returns, defaults are
    // restored and a load during reset is refused.
    task power_drop();
        load(2'h3, BCS_SRC_PLL1, 8'h04);
        por_stable = 1'b0;
        repeat (4) @(negedge clock);
        check_defaults();
        load(2'h3, BCS_SRC_PLL0, 8'hFF);
        chk(pll_en === 2'h0 && mod_clk_en === 8'hFF, "load in reset");
    endtask : power_drop

    // Main sequence.
    initial begin
        fail_count = 0;
        n_checks = 0;
        rst = 1'b1;
        por_stable = 1'b0;
        cfg_load = 1'b0;
        cfg_pll_en = 2'h0;
        cfg_clk_src = BCS_SRC_RC;
        cfg_div = 32'h0;
        cfg_gate = 8'h00;
        repeat (3) @(negedge clock);
        check_defaults();
        rst = 1'b0;
        repeat (5) @(negedge clock);
        check_defaults();
        power_up();
        reconfigure();
        power_drop();
        power_up();
        stop_test();
    end
endmodule : boot_clock_reset_sequencer_tb_top
